/* File: logic/link_slot_regs.sv */
// APB register bank for link status report and hot-plug slot control
//
// What this block does
// - Bit 12 high when using connector clock
// - Bit 12 clear when using independent clock
// - Clock bit hardware-set, same across functions
// - Button enable bit 0, resets zero, notifies
// - Presence enable bit 3, resets zero, notifies
// - Bits 7:6 written drive attention indicator
// - Bits 9:8 written drive power indicator
// - Bit 12 enables link-active change notification
`timescale 1ns/1ns
module link_slot_regs #(
  parameter bit HAS_BUTTON      = 1'b1,
  parameter bit HOTPLUG_CAPABLE = 1'b1,
  parameter bit HAS_ATTN_IND    = 1'b1,
  parameter bit HAS_POWER_IND   = 1'b1,
  parameter bit DLL_REPORTING   = 1'b1
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        uses_connector_clk,
  input  wire link_slot_pkg::link_info_t   link_info,
  input  wire logic                        attn_button,
  input  wire logic                        presence_detect,
  output link_slot_pkg::indicators_t       indicators,
  output logic                             irq
);
  typedef struct packed {
    logic [15:0]                        slot_ctrl;
    logic [link_slot_pkg::NT_WIDTH-1:0] status;
    logic [link_slot_pkg::NT_WIDTH-1:0] mask;
    logic                               shared_clk;
    logic                               clk_captured;
    logic [31:0]                        rdata;
    logic                               ready;
    logic                               slverr;
    logic                               irq;
    link_slot_pkg::indicators_t         ind;
  } regs_state_t;

  regs_state_t state_reg;
  regs_state_t state_next;

  link_slot_pkg::slot_events_t events;

  slot_event_detect u_detect (
    .pclk           (pclk),
    .presetn        (presetn),
    .button_level   (attn_button),
    .presence_level (presence_detect),
    .link_active    (link_info.link_active),
    .events         (events)
  );

  // Bits that exist only where the matching hardware is present
  localparam logic [15:0] SLOT_WMASK =
    (16'(HAS_BUTTON) << link_slot_pkg::SC_BUTTON_EN) |
    (16'(HOTPLUG_CAPABLE) << link_slot_pkg::SC_PRESENCE_EN) |
    ({14'h0, {2{HAS_ATTN_IND}}} << link_slot_pkg::SC_ATTN_LSB) |
    ({14'h0, {2{HAS_POWER_IND}}} << link_slot_pkg::SC_POWER_LSB) |
    (16'(DLL_REPORTING) << link_slot_pkg::SC_DLL_EN);

  logic        setup_cycle;
  logic        wr_en;
  logic        rd_en;
  logic        addr_hit;
  logic [15:0] link_word;
  logic [15:0] wr_half;
  logic [link_slot_pkg::NT_WIDTH-1:0] raise;

  always_comb begin
    link_word = 16'h0000;
    link_word[link_slot_pkg::LS_SPEED_LSB +: 4] = link_info.speed;
    link_word[link_slot_pkg::LS_WIDTH_LSB +: 6] = link_info.width;
    link_word[link_slot_pkg::LS_TRAINING]       = link_info.training;
    link_word[link_slot_pkg::LS_SHARED_CLK]     = state_reg.shared_clk;
    link_word[link_slot_pkg::LS_LINK_ACTIVE]    = link_info.link_active;
  end

  // Zero-wait-state slave: answer in the access cycle after setup
  assign setup_cycle = psel && !penable;
  assign addr_hit    = (paddr == link_slot_pkg::LINK_STATE_REPORT_ADDR) ||
                       (paddr == link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR) ||
                       (paddr == link_slot_pkg::NOTIFY_STATUS_ADDR) ||
                       (paddr == link_slot_pkg::NOTIFY_MASK_ADDR);
  assign wr_en = psel && penable && state_reg.ready && pwrite && addr_hit;
  assign rd_en = setup_cycle && !pwrite;

  always_comb begin
    wr_half = state_reg.slot_ctrl;
    if (pstrb[0]) begin
      wr_half[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      wr_half[15:8] = pwdata[15:8];
    end
  end

  // Event is latched only if its enable is set in the same cycle
  always_comb begin
    raise = '0;
    raise[link_slot_pkg::NT_BUTTON] = events.button_press &&
      state_reg.slot_ctrl[link_slot_pkg::SC_BUTTON_EN];
    raise[link_slot_pkg::NT_PRESENCE] = events.presence_change &&
      state_reg.slot_ctrl[link_slot_pkg::SC_PRESENCE_EN];
    raise[link_slot_pkg::NT_DLL] = DLL_REPORTING && events.link_active_change &&
      state_reg.slot_ctrl[link_slot_pkg::SC_DLL_EN];
  end

  always_comb begin
    state_next = state_reg;
    // Strap is caught once after reset release and then frozen
    if (!state_reg.clk_captured) begin
      state_next.shared_clk   = uses_connector_clk;
      state_next.clk_captured = 1'b1;
    end
    state_next.ready  = setup_cycle;
    state_next.slverr = setup_cycle && !addr_hit;
    // Read data stands only in the access cycle, so stale words never leak out
    state_next.rdata  = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        link_slot_pkg::LINK_STATE_REPORT_ADDR:
          state_next.rdata = {16'h0000, link_word};
        link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR:
          state_next.rdata = {16'h0000, state_reg.slot_ctrl};
        link_slot_pkg::NOTIFY_STATUS_ADDR:
          state_next.rdata = {29'h0, state_reg.status};
        link_slot_pkg::NOTIFY_MASK_ADDR:
          state_next.rdata = {29'h0, state_reg.mask};
        default:
          state_next.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_en) begin
      unique case (paddr)
        link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR: begin
          state_next.slot_ctrl = wr_half & SLOT_WMASK;
          // Reserved indicator code is ignored so the lamp never goes undefined
          if (wr_half[link_slot_pkg::SC_ATTN_LSB +: 2] == 2'h0 && HAS_ATTN_IND) begin
            state_next.slot_ctrl[link_slot_pkg::SC_ATTN_LSB +: 2] =
              state_reg.slot_ctrl[link_slot_pkg::SC_ATTN_LSB +: 2];
          end
          if (wr_half[link_slot_pkg::SC_POWER_LSB +: 2] == 2'h0 && HAS_POWER_IND) begin
            state_next.slot_ctrl[link_slot_pkg::SC_POWER_LSB +: 2] =
              state_reg.slot_ctrl[link_slot_pkg::SC_POWER_LSB +: 2];
          end
        end
        link_slot_pkg::NOTIFY_MASK_ADDR: begin
          if (pstrb[0]) begin
            state_next.mask = pwdata[link_slot_pkg::NT_WIDTH-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Write-one-to-clear, new events win over the clear
    if (wr_en && pstrb[0] && paddr == link_slot_pkg::NOTIFY_STATUS_ADDR) begin
      state_next.status = state_reg.status & ~pwdata[link_slot_pkg::NT_WIDTH-1:0];
    end
    state_next.status = state_next.status | raise;
    state_next.irq    = |(state_next.status & state_next.mask);
    state_next.ind.attn  = state_next.slot_ctrl[link_slot_pkg::SC_ATTN_LSB +: 2];
    state_next.ind.power = state_next.slot_ctrl[link_slot_pkg::SC_POWER_LSB +: 2];
  end

  localparam logic [15:0] SLOT_RESET_EFF = link_slot_pkg::SLOT_CTRL_RESET & SLOT_WMASK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg              <= '0;
      state_reg.slot_ctrl    <= SLOT_RESET_EFF;
      state_reg.ind.attn     <= SLOT_RESET_EFF[link_slot_pkg::SC_ATTN_LSB +: 2];
      state_reg.ind.power    <= SLOT_RESET_EFF[link_slot_pkg::SC_POWER_LSB +: 2];
      state_reg.status       <= link_slot_pkg::NOTIFY_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata     = state_reg.rdata;
  assign pready     = state_reg.ready;
  assign pslverr    = state_reg.slverr;
  assign irq        = state_reg.irq;
  assign indicators = state_reg.ind;

  // Checks
  sequence s_button_event;
    events.button_press && state_reg.slot_ctrl[link_slot_pkg::SC_BUTTON_EN];
  endsequence

  a_button_notify: assert property (@(posedge pclk) disable iff (!presetn)
    s_button_event |=> state_reg.status[link_slot_pkg::NT_BUTTON])
    else $error("button event not latched");

  a_presence_notify: assert property (@(posedge pclk) disable iff (!presetn)
    events.presence_change && state_reg.slot_ctrl[link_slot_pkg::SC_PRESENCE_EN]
    |=> state_reg.status[link_slot_pkg::NT_PRESENCE])
    else $error("presence event not latched");

  a_dll_notify: assert property (@(posedge pclk) disable iff (!presetn)
    events.link_active_change && state_reg.slot_ctrl[link_slot_pkg::SC_DLL_EN]
    |=> state_reg.status[link_slot_pkg::NT_DLL])
    else $error("link active change not latched");

  a_no_spurious_set: assert property (@(posedge pclk) disable iff (!presetn)
    !state_reg.status[link_slot_pkg::NT_BUTTON] &&
    !(events.button_press && state_reg.slot_ctrl[link_slot_pkg::SC_BUTTON_EN])
    |=> !state_reg.status[link_slot_pkg::NT_BUTTON])
    else $error("button status set without enabled event");

  a_clk_stable: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.clk_captured |=> $stable(state_reg.shared_clk))
    else $error("shared clock bit changed after capture");

  a_clk_report: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == link_slot_pkg::LINK_STATE_REPORT_ADDR
    |=> prdata[link_slot_pkg::LS_SHARED_CLK] == $past(state_reg.shared_clk))
    else $error("link report clock bit wrong");

  a_clk_capture: assert property (@(posedge pclk) disable iff (!presetn)
    !state_reg.clk_captured |=> state_reg.shared_clk == $past(uses_connector_clk))
    else $error("clock strap not captured");

  a_attn_drive: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR && HAS_ATTN_IND &&
    pstrb[0] && pwdata[7:6] != 2'h0 |=> indicators.attn == $past(pwdata[7:6]))
    else $error("attention indicator not driven");

  a_power_drive: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR && HAS_POWER_IND &&
    pstrb[1] && pwdata[9:8] != 2'h0 |=> indicators.power == $past(pwdata[9:8]))
    else $error("power indicator not driven");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(state_reg.status & state_reg.mask))
    else $error("irq disagrees with status and mask");

  a_presence_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !state_reg.status[link_slot_pkg::NT_PRESENCE] &&
    !(events.presence_change && state_reg.slot_ctrl[link_slot_pkg::SC_PRESENCE_EN])
    |=> !state_reg.status[link_slot_pkg::NT_PRESENCE])
    else $error("presence status set without enabled event");

  a_dll_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !state_reg.status[link_slot_pkg::NT_DLL] &&
    !(events.link_active_change && state_reg.slot_ctrl[link_slot_pkg::SC_DLL_EN])
    |=> !state_reg.status[link_slot_pkg::NT_DLL])
    else $error("link change status set without enabled event");

  a_absent_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg.slot_ctrl & ~SLOT_WMASK) == 16'h0000)
    else $error("control bit set with no hardware behind it");

  a_attn_legal: assert property (@(posedge pclk) disable iff (!presetn)
    HAS_ATTN_IND |-> indicators.attn != 2'h0)
    else $error("attention lamp on reserved code");

  a_power_legal: assert property (@(posedge pclk) disable iff (!presetn)
    HAS_POWER_IND |-> indicators.power != 2'h0)
    else $error("power lamp on reserved code");

  a_attn_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR &&
    pstrb[0] && pwdata[7:6] == 2'h0 |=> $stable(indicators.attn))
    else $error("reserved attention code reached the lamp");

  a_power_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR &&
    pstrb[1] && pwdata[9:8] == 2'h0 |=> $stable(indicators.power))
    else $error("reserved power code reached the lamp");

  // Bus handshake steps shared by the bus checks below
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |=> pready)
    else $error("no answer in the cycle after setup");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_access |=> !pready)
    else $error("ready held past the access cycle");

  a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data shown outside the access cycle");

  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error flag without ready");
endmodule

/* File: logic/link_slot_pkg.sv */
// Package with register map, field layout and carrier types of the link status and slot block
package link_slot_pkg;
  // Register indices as printed, byte address is four times the index
  localparam logic [7:0]  LINK_STATE_REPORT_IDX    = 8'h12;
  localparam logic [7:0]  SLOT_HOTSWAP_CONTROL_IDX = 8'h18;
  localparam logic [7:0]  NOTIFY_STATUS_IDX        = 8'h19;
  localparam logic [7:0]  NOTIFY_MASK_IDX          = 8'h1A;
  localparam logic [11:0] LINK_STATE_REPORT_ADDR    = {2'h0, LINK_STATE_REPORT_IDX, 2'h0};
  localparam logic [11:0] SLOT_HOTSWAP_CONTROL_ADDR = {2'h0, SLOT_HOTSWAP_CONTROL_IDX, 2'h0};
  localparam logic [11:0] NOTIFY_STATUS_ADDR        = {2'h0, NOTIFY_STATUS_IDX, 2'h0};
  localparam logic [11:0] NOTIFY_MASK_ADDR          = {2'h0, NOTIFY_MASK_IDX, 2'h0};

  // Link state report fields
  localparam int LS_SPEED_LSB   = 0;
  localparam int LS_WIDTH_LSB   = 4;
  localparam int LS_TRAINING    = 11;
  localparam int LS_SHARED_CLK  = 12;
  localparam int LS_LINK_ACTIVE = 13;

  // Slot control fields
  localparam int SC_BUTTON_EN   = 0;
  localparam int SC_PRESENCE_EN = 3;
  localparam int SC_ATTN_LSB    = 6;
  localparam int SC_POWER_LSB   = 8;
  localparam int SC_DLL_EN      = 12;

  // Notify status and mask bits
  localparam int NT_BUTTON   = 0;
  localparam int NT_PRESENCE = 1;
  localparam int NT_DLL      = 2;
  localparam int NT_WIDTH    = 3;

  // Indicator encodings; 2'h0 is the reserved one
  localparam logic [1:0] IND_ON    = 2'h1;
  localparam logic [1:0] IND_BLINK = 2'h2;
  localparam logic [1:0] IND_OFF   = 2'h3;

  // Both lamps off after reset, because code 0 is reserved and must never show
  localparam logic [15:0] SLOT_CTRL_RESET = 16'h03C0;
  localparam logic [NT_WIDTH-1:0] NOTIFY_RESET = 3'h0;

  typedef struct packed {
    logic       shared_clk;
    logic [3:0] speed;
    logic [5:0] width;
    logic       training;
    logic       link_active;
  } link_info_t;

  typedef struct packed {
    logic       button_press;
    logic       presence_change;
    logic       link_active_change;
  } slot_events_t;

  typedef struct packed {
    logic [1:0] attn;
    logic [1:0] power;
  } indicators_t;
endpackage

/* File: logic/slot_event_detect.sv */
// Edge detector that turns slot and link levels into one-cycle event pulses
`timescale 1ns/1ns
module slot_event_detect (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        button_level,
  input  wire logic                        presence_level,
  input  wire logic                        link_active,
  output link_slot_pkg::slot_events_t      events
);
  typedef struct packed {
    logic prev_button;
    logic prev_presence;
    logic prev_link;
    logic primed;
  } det_state_t;

  det_state_t state_reg;
  det_state_t state_next;

  always_comb begin
    state_next               = state_reg;
    state_next.prev_button   = button_level;
    state_next.prev_presence = presence_level;
    state_next.prev_link     = link_active;
    state_next.primed        = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // No events in the first cycle, so reset levels do not look like changes
  assign events.button_press       = state_reg.primed && button_level && !state_reg.prev_button;
  assign events.presence_change    = state_reg.primed && (presence_level != state_reg.prev_presence);
  assign events.link_active_change = state_reg.primed && (link_active != state_reg.prev_link);
endmodule

/* File: test/slot_partner.sv */
// Behavioural slot hardware: attention button, presence switch, link state and clock strap
`timescale 1ns/1ns
module slot_partner (
  input  wire logic                      pclk,
  input  wire logic                      press_req,
  input  wire logic                      card_in,
  input  wire logic                      link_up,
  input  wire logic                      strap_clk,
  output logic                           attn_button,
  output logic                           presence_detect,
  output logic                           uses_connector_clk,
  output link_slot_pkg::link_info_t      link_info
);
  logic [1:0] hold_cnt;
  initial begin
    hold_cnt = 2'h0;
    attn_button = 1'b0;
  end
  // A press is held for a few cycles, so the block sees one clean rising edge
  always @(posedge pclk) begin
    if (press_req) begin
      hold_cnt <= 2'h3;
    end else if (hold_cnt != 2'h0) begin
      hold_cnt <= hold_cnt - 2'h1;
    end
    attn_button <= press_req || (hold_cnt > 2'h1);
  end
  assign presence_detect    = card_in;
  assign uses_connector_clk = strap_clk;
  assign link_info = '{shared_clk: 1'b0, speed: 4'h1, width: 6'h04, training: 1'b0,
                       link_active: link_up};
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the link status and slot control register bank
`timescale 1ns/1ns
module testbench;
  logic                         pclk;
  logic                         presetn;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [11:0]                  paddr;
  logic [31:0]                  pwdata;
  logic [3:0]                   pstrb;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         irq;
  logic                         press_req;
  logic                         card_in;
  logic                         link_up;
  logic                         strap_clk;
  logic                         attn_button;
  logic                         presence_detect;
  logic                         uses_connector_clk;
  link_slot_pkg::link_info_t    link_info;
  link_slot_pkg::indicators_t   indicators;
  int                           n_mismatch;
  int                           n_checks;
  logic [31:0]                  rd_val;
  logic                         rd_err;

  link_slot_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .uses_connector_clk(uses_connector_clk),
    .link_info(link_info), .attn_button(attn_button), .presence_detect(presence_detect),
    .indicators(indicators), .irq(irq));
  slot_partner u_slot (.pclk(pclk), .press_req(press_req), .card_in(card_in),
    .link_up(link_up), .strap_clk(strap_clk), .attn_button(attn_button),
    .presence_detect(presence_detect), .uses_connector_clk(uses_connector_clk),
    .link_info(link_info));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One transfer then one idle cycle, so psel is never assigned twice in a time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) check("apb_ready", 32'h0, 32'h1);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic do_reset(input logic strap);
    presetn <= 1'b0;
    strap_clk <= strap;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_reset_values();
    apb(1'b0, link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR, 32'h0);
    check("slot_enables", rd_val & 32'h1009, 32'h0);
    check("attn_reset_legal", {31'h0, rd_val[7:6] != 2'h0}, 32'h1);
    check("power_reset", {30'h0, rd_val[9:8]}, 32'h3);
    check("ind_reset", {28'h0, indicators}, 32'hF);
    apb(1'b0, link_slot_pkg::LINK_STATE_REPORT_ADDR, 32'h0);
    check("link_state", rd_val, 32'h1041);
    apb(1'b1, link_slot_pkg::LINK_STATE_REPORT_ADDR, 32'h0000EFFF);
    apb(1'b0, link_slot_pkg::LINK_STATE_REPORT_ADDR, 32'h0);
    check("link_state_ro", rd_val, 32'h1041);
    apb(1'b0, 12'h0FC, 32'h0);
    check("unmapped_err", {31'h0, rd_err}, 32'h1);
  endtask

  task automatic t_strap_low();
    do_reset(1'b0);
    apb(1'b0, link_slot_pkg::LINK_STATE_REPORT_ADDR, 32'h0);
    check("shared_clk_clear", rd_val, 32'h0041);
    do_reset(1'b1);
  endtask

  task automatic t_indicators();
    for (int c = 1; c <= 4; c++) begin
      // Code 0 is reserved, so the last pass must leave the lamps at code 3
      apb(1'b1, link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR, {22'h0, 2'(c), 2'(c), 6'h0});
      check("indicators", {28'h0, indicators}, (c == 4) ? 32'hF : {28'h0, 2'(c), 2'(c)});
      apb(1'b0, link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR, 32'h0);
      check("ind_readback", rd_val & 32'h3C0, (c == 4) ? 32'h3C0 : {22'h0, 2'(c), 2'(c), 6'h0});
    end
    // Only the upper lane is written, so the button and presence enables and the attention lamp keep their state
    pstrb <= 4'h2;
    apb(1'b1, link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR, 32'h0000_01C9);
    pstrb <= 4'hF;
    check("strobe_lane", {28'h0, indicators}, 32'hD);
    apb(1'b0, link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR, 32'h0);
    check("strobe_readback", rd_val, 32'h01C0);
  endtask

  task automatic fire(input int i);
    if (i == 0) press_req <= 1'b1;
    else if (i == 1) card_in <= ~card_in;
    else link_up <= ~link_up;
    @(posedge pclk);
    press_req <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask

  task automatic t_events();
    logic [15:0] en [3];
    en = '{16'h0001, 16'h0008, 16'h1000};
    apb(1'b1, link_slot_pkg::NOTIFY_MASK_ADDR, 32'h7);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR, 32'h03C0);
      fire(i);
      apb(1'b0, link_slot_pkg::NOTIFY_STATUS_ADDR, 32'h0);
      check("status_disabled", rd_val, 32'h0);
      apb(1'b1, link_slot_pkg::SLOT_HOTSWAP_CONTROL_ADDR, {16'h0, en[i] | 16'h03C0});
      fire(i);
      apb(1'b0, link_slot_pkg::NOTIFY_STATUS_ADDR, 32'h0);
      check("status_event", rd_val, 32'h1 << i);
      check("irq_raised", {31'h0, irq}, 32'h1);
      apb(1'b1, link_slot_pkg::NOTIFY_MASK_ADDR, 32'h0);
      check("irq_masked", {31'h0, irq}, 32'h0);
      apb(1'b1, link_slot_pkg::NOTIFY_STATUS_ADDR, 32'h7);
      apb(1'b1, link_slot_pkg::NOTIFY_MASK_ADDR, 32'h7);
      apb(1'b0, link_slot_pkg::NOTIFY_STATUS_ADDR, 32'h0);
      check("status_cleared", rd_val, 32'h0);
    end
  endtask

  initial begin
    n_mismatch = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    press_req = 1'b0;
    card_in = 1'b0;
    link_up = 1'b0;
    strap_clk = 1'b1;
    do_reset(1'b1);
    t_reset_values();
    t_strap_low();
    t_indicators();
    t_events();
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end
endmodule
